// ==== design/gmc_params.svh ====
// constants of the gas module command port: address, command codes, status bits, timing
// Behaviour
// - target port works with bus clocks up to 100 kHz and 400 kHz.
// - device answers the 7-bit target address 0x38.
// - no register pointer; every access is a command transaction.
// - after the command write, stop or repeated start are both accepted.
// - a read returns status byte, response parameters, then one checksum byte.
// - a started cleaning run lasts one minute.
// - cleaning runs once per lifetime, marked by a non-volatile bit.
// - each measurement carries a valid or damage self-check status.
// - humidity defaults to 50 percent until the host supplies one.
// - last supplied humidity is kept and applied until replaced.
// - humidity used automatically; relative air index ignores humidity.
// - absolute organic-compound concentration saturates at 6000 ug per cubic metre.
// - checksum is the inverted 8-bit sum, so all bytes sum to 0xFF.
// - surplus write bytes ignored; too few bytes give an error status.
// - a read without a preceding command write returns 0xFF bytes.
// - status bit7 invalid, bit6 checksum, bit5 internal nack, bit4 busy, low nibble self-check (0x0 ok, 0xA damage).
`ifndef GMC_PARAMS_SVH
`define GMC_PARAMS_SVH

// bus addressing and timing
`define GMC_I2C_ADDR 7'h38
`define GMC_CLK_HZ 20000000
`define GMC_CLEAN_TIME_S 60

// command codes that this port executes
`define GMC_CMD_GET_MODE 8'h10
`define GMC_CMD_SET_MODE 8'h11
`define GMC_CMD_SET_HUM 8'h12
`define GMC_CMD_GET_MEAS 8'h18

// operation modes
`define GMC_MODE_RESET 8'h00
`define GMC_MODE_ABS_TVOC 8'h02
`define GMC_MODE_CLEAN 8'h09

// status byte layout
`define GMC_ST_INVALID_BIT 7
`define GMC_ST_CKSUM_BIT 6
`define GMC_ST_INTNACK_BIT 5
`define GMC_ST_BUSY_BIT 4
`define GMC_ST_OK 4'h0
`define GMC_ST_DAMAGE 4'hA

// framing values and limits
`define GMC_CKSUM_TOTAL 8'hFF
`define GMC_BLANK_BYTE 8'hFF
`define GMC_HUM_DEFAULT 8'h32
`define GMC_TVOC_MAX 16'h1770
`define GMC_BYTE_BITS 4'h8

`endif

// ==== design/gmc_pkg.sv ====
// types shared by the gas module command port
package gmc_pkg;

	// events passed from the link side to the command side
	typedef enum logic [2:0] {EV_WSTART, EV_RSTART, EV_BYTE, EV_RBYTE, EV_STOP} gmc_ev_kind_type;

	typedef struct packed {
		gmc_ev_kind_type kind;
		logic [7:0] data;
	} gmc_event_type;

	// bus pins, open drain
	typedef struct packed {
		logic scl;
		logic sda;
	} gmc_pin_in_type;

	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} gmc_pin_out_type;

	// one measurement from the algorithm
	typedef struct packed {
		logic [15:0] tvoc;
		logic [7:0] rel_index;
		logic damage;
	} gmc_meas_type;

	typedef enum logic [3:0] {LK_IDLE, LK_ADDR, LK_ACK_ADDR, LK_WRX, LK_WACK, LK_TX_WAIT,
		LK_TX_LOAD, LK_TX, LK_RACK, LK_WAIT_STOP} gmc_link_state_type;

	// link side state, runs on the link clock
	typedef struct packed {
		gmc_link_state_type st;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic rw;
		logic addressed;
		logic ack_ok;
		gmc_pin_out_type pins;
		logic ev_send;
		gmc_event_type ev;
		logic scl_s1;
		logic scl_s2;
		logic scl_p;
		logic sda_s1;
		logic sda_s2;
		logic sda_p;
		logic rst_s1;
		logic rst_s2;
	} gmc_link_type;

	// command side state, runs on the system clock
	typedef struct packed {
		logic [4:0][7:0] resp;
		logic [2:0] resp_len;
		logic [2:0] rd_idx;
		logic [2:0] rx_cnt;
		logic [7:0] cmd;
		logic [7:0] par;
		logic [7:0] ck;
		logic have_req;
		logic fresh;
		logic [7:0] mode;
		logic [7:0] hum;
		logic [15:0] tvoc;
		logic [7:0] rel_index;
		logic damage;
		logic clean_used;
		logic clean_act;
		logic [30:0] clean_cnt;
		logic nvm_set;
		logic tx_send;
		logic [7:0] tx_byte;
		logic nvm_s1;
		logic nvm_s2;
	} gmc_core_type;

endpackage

// ==== design/gmc_cdc_word.sv ====
// toggle handshake that carries one word between two clock domains
`timescale 1ns/1ps

module gmc_cdc_word
#(
	parameter int W = 8
)
(
	// source domain
	input wire logic src_clk,
	input wire logic src_rst,
	input wire logic src_send,
	input wire logic [W-1:0] src_data,
	// destination domain
	input wire logic dst_clk,
	input wire logic dst_rst,
	output logic dst_pulse,
	output logic [W-1:0] dst_data
);

	logic tog_r;
	logic [W-1:0] hold_r;
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// word is held until the next send; sends must be spaced by a few dst cycles
	always_ff @(posedge src_clk)
	begin
		if (src_rst)
		begin
			tog_r <= 1'b0;
			hold_r <= '0;
		end
		else if (src_send)
		begin
			tog_r <= ~tog_r;
			hold_r <= src_data;
		end
	end

	// s1 feeds s2 only; the edge is seen between s2 and s3
	always_ff @(posedge dst_clk)
	begin
		if (dst_rst)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			dst_pulse <= 1'b0;
			dst_data <= '0;
		end
		else
		begin
			s1_r <= tog_r;
			s2_r <= s1_r;
			s3_r <= s2_r;
			dst_pulse <= s2_r ^ s3_r;
			if (s2_r ^ s3_r)
				dst_data <= hold_r;
		end
	end

endmodule

// ==== design/gmc_cmd_port.sv ====
// serial target port and command interpreter of the gas sensor module
`timescale 1ns/1ps
`include "gmc_params.svh"

module gmc_cmd_port
#(
	parameter int unsigned CLEAN_CYCLES = `GMC_CLEAN_TIME_S * `GMC_CLK_HZ
)
(
	// system clock and reset
	input wire logic clk,
	input wire logic srst,
	// link oversampling clock
	input wire logic link_clk,
	// bus pins
	input wire gmc_pkg::gmc_pin_in_type pin_in,
	output gmc_pkg::gmc_pin_out_type pin_out,
	// measurement results from the algorithm
	input wire logic meas_strobe,
	input wire gmc_pkg::gmc_meas_type meas_in,
	// non-volatile cleaning marker
	input wire logic nvm_clean_done,
	output logic nvm_clean_set,
	// module state
	output logic [7:0] op_mode,
	output logic [7:0] hum_comp,
	output logic clean_active
);
	import gmc_pkg::*;

	gmc_link_type lk_r;
	gmc_link_type lk_nxt;
	gmc_core_type cr_r;
	gmc_core_type cr_nxt;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic ev_pulse;
	gmc_event_type ev_word;
	logic tx_pulse;
	logic [7:0] tx_data;

	// request parameter bytes of each executed command
	function automatic logic req_params(input logic [7:0] code);
		req_params = (code == `GMC_CMD_SET_MODE) || (code == `GMC_CMD_SET_HUM);
	endfunction

	// response parameter bytes of each executed command
	function automatic logic [1:0] resp_params(input logic [7:0] code);
		case (code)
			`GMC_CMD_GET_MODE: resp_params = 2'd1;
			`GMC_CMD_GET_MEAS: resp_params = 2'd3;
			default: resp_params = 2'd0;
		endcase
	endfunction

	function automatic logic known_cmd(input logic [7:0] code);
		known_cmd = (code == `GMC_CMD_GET_MODE) || (code == `GMC_CMD_SET_MODE) ||
			(code == `GMC_CMD_SET_HUM) || (code == `GMC_CMD_GET_MEAS);
	endfunction

	// bus edges seen on the second synchroniser stage and its delayed copy
	assign scl_rise = lk_r.scl_s2 & ~lk_r.scl_p;
	assign scl_fall = ~lk_r.scl_s2 & lk_r.scl_p;
	assign start_cond = lk_r.scl_s2 & lk_r.scl_p & lk_r.sda_p & ~lk_r.sda_s2;
	assign stop_cond = lk_r.scl_s2 & lk_r.scl_p & ~lk_r.sda_p & lk_r.sda_s2;

	// link side: bit engine on the oversampling clock
	always_comb
	begin
		lk_nxt = lk_r;
		lk_nxt.ev_send = 1'b0;
		if (lk_r.rst_s2)
			lk_nxt = '0;
		else if (start_cond)
		begin
			// a repeated start also lands here and readies a new transfer
			lk_nxt.st = LK_ADDR;
			lk_nxt.cnt = 4'h0;
			lk_nxt.pins.sda_oe = 1'b0;
			lk_nxt.pins.scl_oe = 1'b0;
		end
		else if (stop_cond)
		begin
			if (lk_r.addressed)
			begin
				lk_nxt.ev_send = 1'b1;
				lk_nxt.ev.kind = EV_STOP;
			end
			lk_nxt.addressed = 1'b0;
			lk_nxt.st = LK_IDLE;
			lk_nxt.pins.sda_oe = 1'b0;
			lk_nxt.pins.scl_oe = 1'b0;
		end
		else
		begin
			unique case (lk_r.st)
				LK_IDLE, LK_WAIT_STOP:
				begin
				end
				LK_ADDR, LK_WRX:
				begin
					if (scl_rise)
					begin
						lk_nxt.shreg = {lk_r.shreg[6:0], lk_r.sda_s2};
						lk_nxt.cnt = lk_r.cnt + 4'h1;
					end
					else if (scl_fall && lk_r.cnt == `GMC_BYTE_BITS)
					begin
						lk_nxt.cnt = 4'h0;
						if (lk_r.st == LK_ADDR)
						begin
							if (lk_r.shreg[7:1] == `GMC_I2C_ADDR)
							begin
								lk_nxt.addressed = 1'b1;
								lk_nxt.rw = lk_r.shreg[0];
								lk_nxt.pins.sda_oe = 1'b1;
								lk_nxt.st = LK_ACK_ADDR;
								lk_nxt.ev_send = 1'b1;
								lk_nxt.ev.kind = lk_r.shreg[0] ? EV_RSTART : EV_WSTART;
								lk_nxt.ev.data = lk_r.shreg;
							end
							else
								lk_nxt.st = LK_IDLE;
						end
						else
						begin
							// every write byte is acknowledged, surplus ones too
							lk_nxt.ev_send = 1'b1;
							lk_nxt.ev.kind = EV_BYTE;
							lk_nxt.ev.data = lk_r.shreg;
							lk_nxt.pins.sda_oe = 1'b1;
							lk_nxt.st = LK_WACK;
						end
					end
				end
				LK_ACK_ADDR:
				begin
					if (scl_fall)
					begin
						lk_nxt.pins.sda_oe = 1'b0;
						lk_nxt.cnt = 4'h0;
						if (lk_r.rw)
						begin
							lk_nxt.st = LK_TX_WAIT;
							lk_nxt.pins.scl_oe = 1'b1;
							lk_nxt.ev_send = 1'b1;
							lk_nxt.ev.kind = EV_RBYTE;
						end
						else
							lk_nxt.st = LK_WRX;
					end
				end
				LK_WACK:
				begin
					if (scl_fall)
					begin
						lk_nxt.pins.sda_oe = 1'b0;
						lk_nxt.st = LK_WRX;
					end
				end
				LK_TX_WAIT:
				begin
					// clock stays low until the command side answers
					if (tx_pulse)
					begin
						lk_nxt.shreg = tx_data;
						lk_nxt.pins.sda_oe = ~tx_data[7];
						lk_nxt.st = LK_TX_LOAD;
					end
				end
				LK_TX_LOAD:
				begin
					// one link cycle of data setup before the clock is let go
					lk_nxt.pins.scl_oe = 1'b0;
					lk_nxt.cnt = 4'h0;
					lk_nxt.st = LK_TX;
				end
				LK_TX:
				begin
					if (scl_fall)
					begin
						if (lk_r.cnt == 4'h7)
						begin
							lk_nxt.pins.sda_oe = 1'b0;
							lk_nxt.st = LK_RACK;
						end
						else
						begin
							lk_nxt.cnt = lk_r.cnt + 4'h1;
							lk_nxt.shreg = {lk_r.shreg[6:0], 1'b0};
							lk_nxt.pins.sda_oe = ~lk_r.shreg[6];
						end
					end
				end
				LK_RACK:
				begin
					if (scl_rise)
						lk_nxt.ack_ok = ~lk_r.sda_s2;
					else if (scl_fall)
					begin
						if (lk_r.ack_ok)
						begin
							lk_nxt.st = LK_TX_WAIT;
							lk_nxt.pins.scl_oe = 1'b1;
							lk_nxt.ev_send = 1'b1;
							lk_nxt.ev.kind = EV_RBYTE;
						end
						else
							lk_nxt.st = LK_WAIT_STOP;
					end
				end
				default:
					lk_nxt.st = LK_IDLE;
			endcase
		end
		// synchronisers keep sampling through reset
		lk_nxt.rst_s1 = srst;
		lk_nxt.rst_s2 = lk_r.rst_s1;
		lk_nxt.scl_s1 = pin_in.scl;
		lk_nxt.scl_s2 = lk_r.scl_s1;
		lk_nxt.scl_p = lk_r.scl_s2;
		lk_nxt.sda_s1 = pin_in.sda;
		lk_nxt.sda_s2 = lk_r.sda_s1;
		lk_nxt.sda_p = lk_r.sda_s2;
	end

	// link state register
	always_ff @(posedge link_clk)
	begin
		lk_r <= lk_nxt;
	end

	// link events to the command side
	gmc_cdc_word #(.W($bits(gmc_event_type))) u_ev_cdc
	(
		.src_clk(link_clk),
		.src_rst(lk_r.rst_s2),
		.src_send(lk_r.ev_send),
		.src_data(lk_r.ev),
		.dst_clk(clk),
		.dst_rst(srst),
		.dst_pulse(ev_pulse),
		.dst_data(ev_word)
	);

	// response bytes back to the link side
	gmc_cdc_word #(.W(8)) u_tx_cdc
	(
		.src_clk(clk),
		.src_rst(srst),
		.src_send(cr_r.tx_send),
		.src_data(cr_r.tx_byte),
		.dst_clk(link_clk),
		.dst_rst(lk_r.rst_s2),
		.dst_pulse(tx_pulse),
		.dst_data(tx_data)
	);

	// command side: frame collection, evaluation and module state
	always_comb
	begin
		logic np;
		logic [1:0] nr;
		logic [7:0] status;
		logic [7:0] sum;
		logic [7:0] rsum;
		logic [2:0][7:0] rp;
		logic do_eval;
		np = req_params(cr_r.cmd);
		nr = 2'd0;
		status = 8'h00;
		rp = '0;
		do_eval = 1'b0;
		sum = 8'h00;
		rsum = 8'h00;
		cr_nxt = cr_r;
		cr_nxt.tx_send = 1'b0;
		cr_nxt.nvm_set = 1'b0;
		cr_nxt.clean_used = cr_r.clean_used | cr_r.nvm_s2;
		// the checksum covers code, parameter and checksum bytes
		sum = cr_r.cmd + cr_r.ck + (np ? cr_r.par : 8'h00);
		if (!known_cmd(cr_r.cmd))
			status[`GMC_ST_INVALID_BIT] = 1'b1;
		else if (cr_r.rx_cnt < {2'b00, np} + 3'd2)
			status[`GMC_ST_INVALID_BIT] = 1'b1;
		else if (sum != `GMC_CKSUM_TOTAL)
			status[`GMC_ST_CKSUM_BIT] = 1'b1;
		else
		begin
			nr = resp_params(cr_r.cmd);
			case (cr_r.cmd)
				`GMC_CMD_GET_MODE:
					rp[0] = cr_r.mode;
				`GMC_CMD_GET_MEAS:
				begin
					rp[0] = cr_r.tvoc[15:8];
					rp[1] = cr_r.tvoc[7:0];
					rp[2] = cr_r.rel_index;
					status[`GMC_ST_BUSY_BIT] = cr_r.clean_act;
					status[3:0] = cr_r.damage ? `GMC_ST_DAMAGE : `GMC_ST_OK;
				end
				default:
				begin
				end
			endcase
		end
		rsum = status + rp[0] + rp[1] + rp[2];

		// events from the link; a new write readies a new request
		if (ev_pulse)
		begin
			unique case (ev_word.kind)
				EV_WSTART:
				begin
					cr_nxt.rx_cnt = 3'd0;
					cr_nxt.fresh = 1'b1;
					cr_nxt.have_req = 1'b0;
					cr_nxt.rd_idx = 3'd0;
					cr_nxt.cmd = 8'h00;
				end
				EV_BYTE:
				begin
					if (cr_r.rx_cnt == 3'd0)
						cr_nxt.cmd = ev_word.data;
					else if (cr_r.rx_cnt == 3'd1 && np)
						cr_nxt.par = ev_word.data;
					else if (cr_r.rx_cnt == {2'b00, np} + 3'd1)
						cr_nxt.ck = ev_word.data;
					if (cr_r.rx_cnt != 3'd7)
						cr_nxt.rx_cnt = cr_r.rx_cnt + 3'd1;
				end
				EV_RSTART:
				begin
					do_eval = cr_r.fresh;
					cr_nxt.rd_idx = 3'd0;
				end
				EV_RBYTE:
				begin
					// bytes past the frame, or with no request, read as blanks
					cr_nxt.tx_send = 1'b1;
					if (cr_r.have_req && cr_r.rd_idx < cr_r.resp_len)
						cr_nxt.tx_byte = cr_r.resp[cr_r.rd_idx];
					else
						cr_nxt.tx_byte = `GMC_BLANK_BYTE;
					if (cr_r.rd_idx != 3'd7)
						cr_nxt.rd_idx = cr_r.rd_idx + 3'd1;
				end
				EV_STOP:
				begin
					if (cr_r.fresh)
						do_eval = 1'b1;
					else if (cr_r.rd_idx != 3'd0)
						cr_nxt.have_req = 1'b0;
				end
				default:
				begin
				end
			endcase
		end

		// evaluation builds the response frame and runs the command
		if (do_eval)
		begin
			cr_nxt.fresh = 1'b0;
			cr_nxt.have_req = 1'b1;
			cr_nxt.rd_idx = 3'd0;
			cr_nxt.resp = '0;
			cr_nxt.resp[0] = status;
			for (int i = 0; i < 3; i++)
			begin
				if (i < int'(nr))
					cr_nxt.resp[i + 1] = rp[i];
			end
			cr_nxt.resp[{1'b0, nr} + 3'd1] = ~rsum;
			cr_nxt.resp_len = {1'b0, nr} + 3'd2;
			if (status[7:6] == 2'b00)
			begin
				case (cr_r.cmd)
					`GMC_CMD_SET_MODE:
					begin
						if (cr_r.par == `GMC_MODE_CLEAN)
						begin
							// marker is written at start so a cut run never repeats
							if (!(cr_r.clean_used | cr_r.nvm_s2))
							begin
								cr_nxt.clean_used = 1'b1;
								cr_nxt.clean_act = 1'b1;
								cr_nxt.clean_cnt = 31'd0;
								cr_nxt.nvm_set = 1'b1;
							end
						end
						else
							cr_nxt.mode = cr_r.par;
					end
					`GMC_CMD_SET_HUM:
						cr_nxt.hum = cr_r.par;
					default:
					begin
					end
				endcase
			end
		end

		// cleaning run timer; power loss mid-run is the host's hazard
		if (cr_r.clean_act)
		begin
			if (cr_r.clean_cnt == 31'(CLEAN_CYCLES - 1))
				cr_nxt.clean_act = 1'b0;
			else
				cr_nxt.clean_cnt = cr_r.clean_cnt + 31'd1;
		end

		// latch each measurement; relative index passes without humidity
		if (meas_strobe)
		begin
			if (cr_r.mode == `GMC_MODE_ABS_TVOC && meas_in.tvoc > `GMC_TVOC_MAX)
				cr_nxt.tvoc = `GMC_TVOC_MAX;
			else
				cr_nxt.tvoc = meas_in.tvoc;
			cr_nxt.rel_index = meas_in.rel_index;
			cr_nxt.damage = meas_in.damage;
		end

		if (srst)
		begin
			cr_nxt = '0;
			cr_nxt.hum = `GMC_HUM_DEFAULT;
			cr_nxt.mode = `GMC_MODE_RESET;
		end
		cr_nxt.nvm_s1 = nvm_clean_done;
		cr_nxt.nvm_s2 = cr_r.nvm_s1;
	end

	// command side state register
	always_ff @(posedge clk)
	begin
		cr_r <= cr_nxt;
	end

	// outputs straight from the state registers
	assign pin_out = lk_r.pins;
	assign nvm_clean_set = cr_r.nvm_set;
	assign op_mode = cr_r.mode;
	assign hum_comp = cr_r.hum;
	assign clean_active = cr_r.clean_act;

endmodule

// ==== tb/gmc_chk.sv ====
// assertion checker for the gas module command port, bound to its top module
`timescale 1ns/1ps

module gmc_chk
#(
	parameter int unsigned CLEAN_CYCLES = 200
)
(
	// clocks and reset
	input wire logic clk,
	input wire logic srst,
	input wire logic link_clk,
	// bus pins
	input wire gmc_pkg::gmc_pin_in_type pin_in,
	input wire gmc_pkg::gmc_pin_out_type pin_out,
	// measurement and cleaning marker
	input wire logic meas_strobe,
	input wire gmc_pkg::gmc_meas_type meas_in,
	input wire logic nvm_clean_done,
	input wire logic nvm_clean_set,
	// module state
	input wire logic [7:0] op_mode,
	input wire logic [7:0] hum_comp,
	input wire logic clean_active
);
	import gmc_pkg::*;
	logic [31:0] run_r;
	logic done_r;
	// length of the running clean, and whether one has ended since reset
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			run_r <= 32'h0;
			done_r <= 1'b0;
		end
		else
		begin
			run_r <= clean_active ? run_r + 32'h1 : 32'h0;
			if (!clean_active && run_r != 32'h0)
				done_r <= 1'b1;
		end
	end
	a_reset_vals: assert property (@(posedge clk) srst |=> hum_comp == 8'h32
		&& op_mode == 8'h00 && !clean_active && !nvm_clean_set) else $error("reset values");
	a_clean_len: assert property (@(posedge clk) disable iff (srst)
		$fell(clean_active) |-> run_r == CLEAN_CYCLES) else $error("clean run length");
	a_clean_marked: assert property (@(posedge clk) disable iff (srst)
		$rose(clean_active) |-> nvm_clean_set || $past(nvm_clean_set)) else $error("no marker");
	a_marker_pulse: assert property (@(posedge clk) disable iff (srst)
		nvm_clean_set |=> !nvm_clean_set) else $error("marker not a pulse");
	a_clean_once: assert property (@(posedge clk) disable iff (srst)
		done_r |-> !$rose(clean_active)) else $error("second clean run");
	a_nvm_blocks: assert property (@(posedge clk) disable iff (srst)
		nvm_clean_done [*4] |=> !$rose(clean_active)) else $error("clean despite marker");
	a_mode_kept: assert property (@(posedge clk) disable iff (srst)
		op_mode != 8'h09) else $error("clean became mode");
	a_stretch_low: assert property (@(posedge link_clk) disable iff (srst)
		$rose(pin_out.scl_oe) |-> !$past(pin_in.scl)) else $error("stretch in high phase");
	a_stretch_bound: assert property (@(posedge link_clk) disable iff (srst)
		pin_out.scl_oe |-> ##[1:40] !pin_out.scl_oe) else $error("stretch too long");
	a_sda_steady: assert property (@(posedge link_clk) disable iff (srst)
		pin_in.scl && $past(pin_in.scl) |-> $stable(pin_out.sda_oe)) else $error("sda moved");
	c_clean: cover property (@(posedge clk) $rose(clean_active));
	c_stretch: cover property (@(posedge link_clk) $rose(pin_out.scl_oe));
	c_marker: cover property (@(posedge clk) nvm_clean_set);
endmodule

bind gmc_cmd_port gmc_chk #(.CLEAN_CYCLES(CLEAN_CYCLES)) chk (.clk(clk), .srst(srst),
	.link_clk(link_clk), .pin_in(pin_in), .pin_out(pin_out), .meas_strobe(meas_strobe),
	.meas_in(meas_in), .nvm_clean_done(nvm_clean_done), .nvm_clean_set(nvm_clean_set),
	.op_mode(op_mode), .hum_comp(hum_comp), .clean_active(clean_active));

// ==== tb/gmc_host.sv ====
// bus controller model: start, stop, byte write and byte read on open-drain wires
`timescale 1ns/1ps

module gmc_host
(
	// device pull-downs
	input wire logic dev_scl_oe,
	input wire logic dev_sda_oe,
	// resolved wire levels
	output gmc_pkg::gmc_pin_in_type pin
);
	import gmc_pkg::*;
	logic scl_dn = 1'b0;
	logic sda_dn = 1'b0;
	int half_ns = 1250;
	// stretches that outlast the 40 us wait, read by the bench at the close
	int stuck = 0;
	// pull-ups: a released line reads high
	assign pin = {~(scl_dn | dev_scl_oe), ~(sda_dn | dev_sda_oe)};
	// release the clock, wait out any stretch, then the high time
	task automatic scl_up();
		int n;
		scl_dn = 1'b0;
		n = 0;
		while (!pin.scl && n < 4000)
		begin
			#10;
			n++;
		end
		if (n == 4000)
			stuck++;
		#(half_ns);
	endtask
	task automatic bit_io(input logic v, output logic s);
		sda_dn = ~v;
		#(half_ns / 2);
		scl_up();
		s = pin.sda;
		scl_dn = 1'b1;
		#(half_ns / 2);
	endtask
	task automatic start();
		sda_dn = 1'b0;
		#(half_ns / 2);
		scl_up();
		sda_dn = 1'b1;
		#(half_ns);
		scl_dn = 1'b1;
		#(half_ns / 2);
	endtask
	task automatic stop();
		sda_dn = 1'b1;
		#(half_ns / 2);
		scl_up();
		sda_dn = 1'b0;
		#(half_ns * 2);
	endtask
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	// last byte of a read is not acknowledged
	task automatic get_byte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, b[i]);
		bit_io(last, s);
	endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the gas module command port
`timescale 1ns/1ps
`include "gmc_params.svh"

module tb;
	import gmc_pkg::*;
	localparam int unsigned CLEAN = 8000;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic srst = 1'b1;
	logic meas_strobe = 1'b0;
	gmc_meas_type meas_in = '0;
	logic nvm_clean_done = 1'b0;
	gmc_pin_in_type pin_in;
	gmc_pin_out_type pin_out;
	logic nvm_clean_set;
	logic [7:0] op_mode;
	logic [7:0] hum_comp;
	logic clean_active;
	int fails = 0;
	int n_compared = 0;
	int cycles = 0;
	int pulses = 0;
	always #25 clk = ~clk;
	always #80 link_clk = ~link_clk;
	gmc_cmd_port #(.CLEAN_CYCLES(CLEAN)) DUT (.clk(clk), .srst(srst), .link_clk(link_clk),
		.pin_in(pin_in), .pin_out(pin_out), .meas_strobe(meas_strobe), .meas_in(meas_in),
		.nvm_clean_done(nvm_clean_done), .nvm_clean_set(nvm_clean_set), .op_mode(op_mode),
		.hum_comp(hum_comp), .clean_active(clean_active));
	gmc_host host (.dev_scl_oe(pin_out.scl_oe), .dev_sda_oe(pin_out.sda_oe), .pin(pin_in));
	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// cycle ceiling and marker pulse count
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (nvm_clean_set === 1'b1)
			pulses <= pulses + 1;
		if (cycles == 90000)
		begin
			fails = fails + 1;
			report_and_stop();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] ck(input logic [31:0] v);
		return ~(v[31:24] + v[23:16] + v[15:8] + v[7:0]);
	endfunction
	// write frame w (nw bytes), then read nr bytes against exp; rs joins them by repeated start
	task automatic xfer(input logic [6:0] adr, input int nw, input logic [31:0] w,
		input int nr, input logic [39:0] exp, input logic rs);
		logic a;
		logic [7:0] b;
		if (nw > 0)
		begin
			host.start();
			host.put_byte({adr, 1'b0}, a);
			check(a, adr == `GMC_I2C_ADDR);
			for (int i = 0; i < nw && a; i++)
			begin
				host.put_byte(w[31 - 8 * i -: 8], a);
				check(a, 1'b1);
			end
			if (!rs)
				host.stop();
		end
		if (nr > 0)
		begin
			host.start();
			host.put_byte({adr, 1'b1}, a);
			check(a, adr == `GMC_I2C_ADDR);
			for (int i = 0; i < nr; i++)
			begin
				host.get_byte(i == nr - 1, b);
				check(b, exp[39 - 8 * i -: 8]);
			end
			host.stop();
		end
		repeat (30) @(posedge clk);
	endtask
	task automatic meas(input logic [15:0] t, input logic [7:0] r, input logic d);
		@(posedge clk);
		#1 meas_in = '{tvoc: t, rel_index: r, damage: d};
		meas_strobe = 1'b1;
		@(posedge clk);
		#1 meas_strobe = 1'b0;
	endtask
	// held high for 11 clk edges; the link side needs only three of its own
	task automatic do_reset();
		@(posedge clk);
		#1 srst = 1'b1;
		repeat (11) @(posedge clk);
		#1 srst = 1'b0;
		repeat (8) @(posedge clk);
	endtask
	initial
	begin
		do_reset();
		check(hum_comp, 8'h32);
		host.half_ns = 5000;
		xfer(7'h38, 0, 0, 2, 40'hFFFF000000, 0);
		host.half_ns = 1250;
		xfer(7'h39, 2, {8'h10, 8'hEF, 16'h0}, 0, 0, 0);
		xfer(7'h38, 3, {8'h12, 8'h28, ck(32'h1228), 8'h0}, 2, {16'h00FF, 24'h0}, 0);
		check(hum_comp, 8'h28);
		xfer(7'h38, 3, {8'h12, 8'h50, 16'h0}, 2, {16'h40BF, 24'h0}, 0);
		check(hum_comp, 8'h28);
		xfer(7'h38, 2, {8'h00, 8'hFF, 16'h0}, 2, {16'h807F, 24'h0}, 0);
		xfer(7'h38, 2, {8'h11, 24'h0}, 2, {16'h807F, 24'h0}, 0);
		xfer(7'h38, 3, {8'h11, 8'h02, ck(32'h1102), 8'h0}, 2, {16'h00FF, 24'h0}, 0);
		check(op_mode, 8'h02);
		xfer(7'h38, 3, {8'h10, 8'hEF, 16'hAA00}, 4, {32'h0002FDFF, 8'h0}, 1);
		xfer(7'h38, 0, 0, 2, 40'hFFFF000000, 0);
		meas(16'h1771, 8'h64, 1'b0);
		xfer(7'h38, 2, {16'h18E7, 16'h0}, 5, {32'h00177064, ck(32'h00177064)}, 0);
		meas(16'h0123, 8'h64, 1'b1);
		xfer(7'h38, 2, {16'h18E7, 16'h0}, 5, {32'h0A012364, ck(32'h0A012364)}, 0);
		meas(16'h0100, 8'h10, 1'b0);
		xfer(7'h38, 3, {8'h11, 8'h09, ck(32'h1109), 8'h0}, 2, {16'h00FF, 24'h0}, 0);
		check(clean_active, 1'b1);
		xfer(7'h38, 2, {16'h18E7, 16'h0}, 1, {8'h10, 32'h0}, 0);
		for (int n = 0; n < 10000 && clean_active !== 1'b0; n++)
			@(posedge clk);
		xfer(7'h38, 3, {8'h11, 8'h09, ck(32'h1109), 8'h0}, 2, {16'h00FF, 24'h0}, 0);
		check({clean_active, 8'(pulses)}, 9'h001);
		check(op_mode, 8'h02);
		#1 nvm_clean_done = 1'b1;
		do_reset();
		check(hum_comp, 8'h32);
		xfer(7'h38, 3, {8'h11, 8'h09, ck(32'h1109), 8'h0}, 2, {16'h00FF, 24'h0}, 0);
		check({clean_active, 8'(pulses)}, 9'h001);
		check(16'(host.stuck), 16'h0000);
		report_and_stop();
	end
endmodule
